// *** vic_pkg.sv ***
package vic_pkg;
  // source counts and field widths
  localparam int NUM_IRQ = 246;
  localparam int NUM_TRAP = 6;
  localparam int NUM_DMA = 4;
  localparam int PRIO_W = 3;
  localparam int PRIO_FIELD_W = 4;
  localparam int VEC_W = 8;
  localparam int ADDR_W = 24;
  localparam int BOOT_LIM_W = 13;
  localparam int CNT_W = 3;
  localparam int FLAG_WORD_W = 16;

  // vector numbering: irq n sits at vector n + IRQ_VEC_OFS
  localparam int IRQ_VEC_OFS = 8;
  localparam int DMA_IRQ_BASE = 16;
  localparam logic [2:0] TRAP_LEVEL = 3'h7;

  // table placement, in program memory address units
  localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h00_0004;
  localparam logic [23:0] RESET_ADDR = 24'h00_0000;
  localparam int PAGE_SHIFT = 11;
  localparam logic [12:0] BOOT_LIM_MIN = 13'h0002;
  localparam logic [12:0] BOOT_LIM_ONE = 13'h0001;

  // fixed latencies in clock cycles
  localparam logic [2:0] ENTRY_CYCLES = 3'h4;
  localparam logic [2:0] RETURN_CYCLES = 3'h3;
  localparam logic [2:0] VEC_CAP_CYCLE = 3'h2;

  // named sources
  localparam int IRQ_BUS1_COLL = 173;
  localparam int IRQ_BUS2_COLL = 174;
  localparam int IRQ_CONV_CMP0 = 177;
  localparam int IRQ_CONV_FLT0 = 179;
  localparam logic [7:0] VEC_BUS1_COLL = 8'hB5;
  localparam logic [7:0] VEC_BUS2_COLL = 8'hB6;
  localparam logic [7:0] VEC_CONV_CMP0 = 8'hB9;
  localparam logic [7:0] VEC_CONV_CMP1 = 8'hBA;
  localparam logic [7:0] VEC_CONV_FLT0 = 8'hBB;
  localparam logic [7:0] VEC_CONV_FLT1 = 8'hBC;
  localparam logic [23:0] ADDR_BUS1_COLL = 24'h00_016E;
  localparam logic [23:0] ADDR_BUS2_COLL = 24'h00_0170;
  localparam logic [23:0] ADDR_CONV_CMP0 = 24'h00_0176;
  localparam logic [23:0] ADDR_CONV_FLT0 = 24'h00_017A;

  typedef enum logic [1:0] {
    VIC_IDLE,
    VIC_ENTRY,
    VIC_SERVE,
    VIC_RETURN
  } vic_state_t;

  // each vector occupies two address units from the table base
  function automatic logic [23:0] vic_entry_addr(input logic [23:0] base,
                                                 input logic [7:0] vec);
    return base + {15'h0000, vec, 1'b0};
  endfunction
endpackage

// *** vic_controller.sv ***
`timescale 1ns/1ns
// Operation
// - merge all source requests into one request
// - seven levels, three-bit level in a four-bit field per source
// - primary table starts at word 0x000004
// - six trap vectors plus 246 source vectors
// - entry holds 24-bit service routine address
// - equal level: lower vector address wins
// - entry and return take fixed cycle counts
// - alternate table needs segment, fuse, enable
// - enabled alternate table serves every vector
// - alternate base is last boot page start
// - tables inherit boot segment code protection
// - reset bypasses controller, execution at zero
// - bus one collision: vector 181, 0x00016E
// - bus two collision: vector 182, 0x000170
// - comparator zero vector 185, one 186
// - filter zero vector 187, one 188
// - dma channel bits live in controller
module vic_controller (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [vic_pkg::NUM_IRQ-1:0] irq_src_i,
  input wire logic [vic_pkg::NUM_DMA-1:0] dma_event_i,
  input wire logic [vic_pkg::NUM_IRQ-1:0] flag_clr_i,
  input wire logic [vic_pkg::NUM_IRQ-1:0] irq_enable_i,
  input wire logic [vic_pkg::NUM_IRQ*vic_pkg::PRIO_FIELD_W-1:0] prio_field_i,
  input wire logic [vic_pkg::PRIO_W-1:0] cpu_prio_i,
  input wire logic [vic_pkg::NUM_TRAP-1:0] trap_i,
  input wire logic ack_i,
  input wire logic ret_i,
  input wire logic [vic_pkg::ADDR_W-1:0] vec_data_i,
  input wire logic boot_seg_defined_i,
  input wire logic alt_table_config_disable_i,
  input wire logic alt_table_enable_i,
  input wire logic [vic_pkg::BOOT_LIM_W-1:0] boot_segment_limit_i,
  input wire logic code_protect_i,
  output logic irq_req_o,
  output logic [vic_pkg::PRIO_W-1:0] irq_level_o,
  output logic [vic_pkg::VEC_W-1:0] vec_num_o,
  output logic vec_rd_o,
  output logic [vic_pkg::ADDR_W-1:0] vec_addr_o,
  output logic vec_prot_o,
  output logic [vic_pkg::ADDR_W-1:0] isr_addr_o,
  output logic isr_valid_o,
  output logic ret_done_o,
  output logic [vic_pkg::NUM_IRQ-1:0] flag_status_o,
  output logic alt_active_o
);
  import vic_pkg::*;

  vic_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [NUM_IRQ-1:0] flag_reg;
  logic [NUM_IRQ-1:0] flag_set;
  logic [NUM_IRQ-1:0] pend;
  logic [NUM_TRAP-1:0] trap_reg;
  logic req_reg;
  logic [PRIO_W-1:0] lvl_reg;
  logic [VEC_W-1:0] vec_reg;
  logic rd_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic prot_reg;
  logic [ADDR_W-1:0] isr_reg;
  logic isr_valid_reg;
  logic ret_done_reg;
  logic alt_reg;
  logic [ADDR_W-1:0] alt_base_reg;
  logic [ADDR_W-1:0] table_base;
  logic take;
  logic [8:0] irq_pick;
  logic [PRIO_W-1:0] irq_lvl;
  logic trap_any;
  logic [VEC_W-1:0] trap_vec;

  // returns {found, irq}; scanning downward with >= leaves the lowest
  // number among equal levels, so natural order breaks the tie
  function automatic logic [8:0] pick_irq(
    input logic [NUM_IRQ-1:0] p,
    input logic [NUM_IRQ*PRIO_FIELD_W-1:0] pri,
    output logic [PRIO_W-1:0] lvl
  );
    logic found;
    logic [7:0] idx;
    logic [PRIO_W-1:0] best;
    logic [PRIO_W-1:0] f;
    found = 1'b0;
    idx = 8'h00;
    best = '0;
    f = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      f = pri[i*PRIO_FIELD_W +: PRIO_W];
      if (p[i] && (!found || f >= best)) begin
        found = 1'b1;
        best = f;
        idx = 8'(i);
      end
    end
    lvl = best;
    return {found, idx};
  endfunction

  // flag set sources: peripheral lines, dma channels at their slots
  generate
    for (genvar i = 0; i < NUM_IRQ; i++) begin : g_src
      if (i >= DMA_IRQ_BASE && i < DMA_IRQ_BASE + NUM_DMA) begin : g_dma
        assign flag_set[i] = irq_src_i[i] | dma_event_i[i-DMA_IRQ_BASE];
      end else begin : g_per
        assign flag_set[i] = irq_src_i[i];
      end
      // level 0 can never beat the core, so it acts as disabled
      assign pend[i] = flag_reg[i] & irq_enable_i[i] &
        (prio_field_i[i*PRIO_FIELD_W +: PRIO_W] > cpu_prio_i);
    end
  endgenerate

  // winner search: traps first in number order, then sources
  always_comb begin
    irq_lvl = '0;
    irq_pick = pick_irq(pend, prio_field_i, irq_lvl);
    trap_any = |trap_reg;
    trap_vec = '0;
    for (int k = NUM_TRAP - 1; k >= 0; k--) begin
      if (trap_reg[k]) begin
        trap_vec = 8'(k);
      end
    end
  end

  assign take = (state_reg == VIC_IDLE) && req_reg && ack_i;
  assign table_base = alt_reg ? alt_base_reg : PRIMARY_TABLE_BASE;

  // sticky flags; an event in the clearing cycle is kept
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_reg <= '0;
    end else if (clk_en_i) begin
      flag_reg <= (flag_reg & ~flag_clr_i) | flag_set;
    end
  end

  // traps cannot be masked; taking one retires it unless it recurs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trap_reg <= '0;
    end else if (clk_en_i) begin
      for (int k = 0; k < NUM_TRAP; k++) begin
        if (take && vec_reg == 8'(k)) begin
          trap_reg[k] <= trap_i[k];
        end else begin
          trap_reg[k] <= trap_reg[k] | trap_i[k];
        end
      end
    end
  end

  // request to the core, refreshed only while idle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_reg <= 1'b0;
      lvl_reg <= '0;
      vec_reg <= '0;
    end else if (clk_en_i) begin
      if (state_reg == VIC_IDLE && !take) begin
        req_reg <= trap_any | irq_pick[8];
        if (trap_any) begin
          lvl_reg <= TRAP_LEVEL;
          vec_reg <= trap_vec;
        end else begin
          lvl_reg <= irq_lvl;
          vec_reg <= irq_pick[7:0] + 8'(IRQ_VEC_OFS);
        end
      end else begin
        req_reg <= 1'b0;
      end
    end
  end

  // alternate table qualification and base, held in registers so the
  // vector fetch never sees a half-changed boot limit
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alt_reg <= 1'b0;
      alt_base_reg <= RESET_ADDR;
    end else if (clk_en_i) begin
      alt_reg <= boot_seg_defined_i && alt_table_config_disable_i &&
        alt_table_enable_i && boot_segment_limit_i >= BOOT_LIM_MIN;
      alt_base_reg <= ADDR_W'({11'h000, boot_segment_limit_i - BOOT_LIM_ONE}
        << PAGE_SHIFT);
    end
  end

  // entry and return sequencer with data-independent latency
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= VIC_IDLE;
      cnt_reg <= '0;
      isr_valid_reg <= 1'b0;
      ret_done_reg <= 1'b0;
    end else if (clk_en_i) begin
      isr_valid_reg <= 1'b0;
      ret_done_reg <= 1'b0;
      case (state_reg)
        VIC_IDLE: begin
          if (take) begin
            state_reg <= VIC_ENTRY;
            cnt_reg <= 3'h1;
          end
        end
        VIC_ENTRY: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == ENTRY_CYCLES - 3'h1) begin
            isr_valid_reg <= 1'b1;
            state_reg <= VIC_SERVE;
          end
        end
        VIC_SERVE: begin
          if (ret_i) begin
            state_reg <= VIC_RETURN;
            cnt_reg <= 3'h1;
          end
        end
        VIC_RETURN: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == RETURN_CYCLES - 3'h1) begin
            ret_done_reg <= 1'b1;
            state_reg <= VIC_IDLE;
          end
        end
        default: begin
          state_reg <= VIC_IDLE;
        end
      endcase
    end
  end

  // vector fetch: one read strobe right after acceptance
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_reg <= 1'b0;
      addr_reg <= RESET_ADDR;
      prot_reg <= 1'b0;
    end else if (clk_en_i) begin
      rd_reg <= take;
      if (take) begin
        addr_reg <= vic_entry_addr(table_base, vec_reg);
        prot_reg <= code_protect_i;
      end
    end
  end

  // routine address captured at a fixed point of the entry
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      isr_reg <= RESET_ADDR;
    end else if (clk_en_i) begin
      if (state_reg == VIC_ENTRY && cnt_reg == VEC_CAP_CYCLE) begin
        isr_reg <= vec_data_i;
      end
    end
  end

  assign irq_req_o = req_reg;
  assign irq_level_o = lvl_reg;
  assign vec_num_o = vec_reg;
  assign vec_rd_o = rd_reg;
  assign vec_addr_o = addr_reg;
  assign vec_prot_o = prot_reg;
  assign isr_addr_o = isr_reg;
  assign isr_valid_o = isr_valid_reg;
  assign ret_done_o = ret_done_reg;
  assign flag_status_o = flag_reg;
  assign alt_active_o = alt_reg;

  // checks, all on the system clock
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_take;
    irq_req_o && ack_i && clk_en_i && state_reg == VIC_IDLE;
  endsequence

  sequence s_entry_run;
    s_take ##1 clk_en_i [*3];
  endsequence

  sequence s_ret_run;
    (state_reg == VIC_SERVE && ret_i && clk_en_i) ##1 clk_en_i [*2];
  endsequence

  flag_set_wins_a: assert property (
    clk_en_i && |flag_set |=>
      (flag_status_o & $past(flag_set)) == $past(flag_set))
    else $error("flag event lost");

  take_drops_req_a: assert property (
    s_take |=> !irq_req_o && vec_rd_o)
    else $error("acceptance did not start fetch");

  entry_latency_a: assert property (
    s_entry_run |=> isr_valid_o)
    else $error("entry latency wrong");

  return_latency_a: assert property (
    s_ret_run |=> ret_done_o && state_reg == VIC_IDLE)
    else $error("return latency wrong");

  level_above_core_a: assert property (
    irq_req_o && !$past(trap_any) && $past(clk_en_i) |->
      irq_level_o > $past(cpu_prio_i))
    else $error("request at or below core level");

  alt_gate_a: assert property (
    alt_active_o |-> $past(alt_table_enable_i) &&
      $past(alt_table_config_disable_i) && $past(boot_seg_defined_i))
    else $error("alternate table without qualification");

  bus1_vec_a: assert property (
    vec_rd_o && vec_num_o == VEC_BUS1_COLL && !$past(alt_reg) |->
      vec_addr_o == ADDR_BUS1_COLL)
    else $error("bus one collision vector address");

  bus2_vec_a: assert property (
    vec_rd_o && vec_num_o == VEC_BUS2_COLL && !$past(alt_reg) |->
      vec_addr_o == ADDR_BUS2_COLL)
    else $error("bus two collision vector address");

  cmp0_vec_a: assert property (
    vec_rd_o && vec_num_o == VEC_CONV_CMP0 && !$past(alt_reg) |->
      vec_addr_o == ADDR_CONV_CMP0)
    else $error("comparator vector address");

  flt0_vec_a: assert property (
    vec_rd_o && vec_num_o == VEC_CONV_FLT0 && !$past(alt_reg) |->
      vec_addr_o == ADDR_CONV_FLT0)
    else $error("filter vector address");

  isr_capture_a: assert property (
    s_entry_run |=> isr_addr_o == $past(vec_data_i, 2))
    else $error("routine address not from vector entry");
endmodule

// *** vic_core_model.sv ***
`timescale 1ns/1ns
// stand-in for the core: takes requests, answers fetches, returns later
module vic_core_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic irq_req_i,
  input wire logic vec_rd_i,
  input wire logic [23:0] vec_addr_i,
  input wire logic isr_valid_i,
  input wire logic [3:0] ret_dly_i,
  output logic ack_o,
  output logic ret_o,
  output logic [23:0] vec_data_o
);
  logic [3:0] wait_reg;
  logic busy_reg;

  // one ack per request; dropped right after the taking edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) ack_o <= 1'b0;
    else ack_o <= irq_req_i && !ack_o;
  end

  // word valid only the cycle after the strobe; toggles otherwise so
  // a late sample cannot pass by luck; every entry, used or not, holds
  // a handler address, so no fetch ever lands on an empty slot
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) vec_data_o <= 24'h00_0000;
    else if (vec_rd_i) vec_data_o <= {8'hC3, vec_addr_i[15:0]};
    else vec_data_o <= ~vec_data_o;
  end

  // return after ret_dly_i idle cycles of service
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
      wait_reg <= 4'h0;
      ret_o <= 1'b0;
    end else begin
      ret_o <= 1'b0;
      if (isr_valid_i) begin
        busy_reg <= 1'b1;
        wait_reg <= ret_dly_i;
      end else if (busy_reg && wait_reg == 4'h0) begin
        busy_reg <= 1'b0;
        ret_o <= 1'b1;
      end else if (busy_reg) wait_reg <= wait_reg - 4'h1;
    end
  end
endmodule

// *** vectored_interrupt_controller_tb_top.sv ***
`timescale 1ns/1ns
module vectored_interrupt_controller_tb_top;
  import vic_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [245:0] src = '0;
  logic [245:0] clr = '0;
  logic [245:0] en = '1;
  logic [983:0] prio = '0;
  logic [3:0] dma = 4'h0;
  logic [2:0] cpu_prio = 3'h0;
  logic [5:0] trap = 6'h00;
  logic bseg = 1'b0, fuse = 1'b0, alt_en = 1'b0, prot = 1'b0;
  logic [12:0] blim = 13'h0000;
  logic clk_en = 1'b1;
  logic [3:0] ret_dly = 4'h0;
  logic ack, ret, req, vrd, vprot, isr_v, rdone, alt, prot_seen;
  logic [23:0] vdata, vaddr, isr;
  logic [2:0] lvl;
  logic [7:0] vnum;
  logic [245:0] flags;
  int cyc = 0, t_ack = 0, t_ret = 0, errors = 0, cmp_count = 0, k;
  int irqs[6] = '{173, 174, 177, 178, 179, 180};
  logic [23:0] adrs[6] = '{24'h00_016E, 24'h00_0170, 24'h00_0176,
    24'h00_0178, 24'h00_017A, 24'h00_017C};

  always #10 clk = ~clk;

  vic_controller u_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(clk_en),
    .irq_src_i(src), .dma_event_i(dma), .flag_clr_i(clr),
    .irq_enable_i(en), .prio_field_i(prio), .cpu_prio_i(cpu_prio),
    .trap_i(trap), .ack_i(ack), .ret_i(ret), .vec_data_i(vdata),
    .boot_seg_defined_i(bseg), .alt_table_config_disable_i(fuse),
    .alt_table_enable_i(alt_en), .boot_segment_limit_i(blim),
    .code_protect_i(prot), .irq_req_o(req), .irq_level_o(lvl),
    .vec_num_o(vnum), .vec_rd_o(vrd), .vec_addr_o(vaddr),
    .vec_prot_o(vprot), .isr_addr_o(isr), .isr_valid_o(isr_v),
    .ret_done_o(rdone), .flag_status_o(flags), .alt_active_o(alt));

  vic_core_model u_core (.sys_clk_i(clk), .rst_n_i(rst_n),
    .irq_req_i(req), .vec_rd_i(vrd), .vec_addr_i(vaddr),
    .isr_valid_i(isr_v), .ret_dly_i(ret_dly), .ack_o(ack), .ret_o(ret),
    .vec_data_o(vdata));

  // cycle stamps for latency checks; also the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // stamp the cycle in which ack or return is sampled high
    if (req && ack) t_ack <= cyc;
    if (ret) t_ret <= cyc;
    if (vrd) prot_seen <= vprot;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      errors++;
    end
  endtask

  task automatic fire(input logic [245:0] m, input logic [5:0] t);
    @(posedge clk);
    src <= m;
    trap <= t;
    @(posedge clk);
    src <= '0;
    trap <= 6'h00;
  endtask

  // wait out one entry and return; n < 0 marks a trap
  task automatic serve(input int n, input logic [23:0] ea);
    int i;
    i = 0;
    while (isr_v !== 1'b1 && i < 60) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("isr_valid", 24'h1, isr_v);
    chk("vec_addr", ea, vaddr);
    chk("isr_addr", {8'hC3, ea[15:0]}, isr);
    chk("entry_cyc", 24'(ENTRY_CYCLES), 24'(cyc - t_ack));
    if (n < 0) begin
      chk("level", 24'(TRAP_LEVEL), lvl);
    end else begin
      chk("level", 24'(prio[4*n +: 3]), lvl);
      chk("vec_num", 24'(n + IRQ_VEC_OFS), vnum);
      chk("flag", 24'h1, flags[n]);
      @(posedge clk);
      clr[n] <= 1'b1;
      @(posedge clk);
      clr[n] <= 1'b0;
    end
    i = 0;
    while (rdone !== 1'b1 && i < 60) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("ret_cyc", 24'(RETURN_CYCLES), 24'(cyc - t_ret));
    // hand back on an edge so the next stimulus lands on one
    @(posedge clk);
  endtask

  // source must stay silent while gated
  task automatic quiet(input logic [245:0] m);
    logic s;
    s = 1'b0;
    fire(m, 6'h00);
    repeat (6) begin
      @(posedge clk);
      #1;
      s = s | req;
    end
    chk("req_gated", 24'h0, s);
    @(posedge clk);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1;
    chk("req_rst", 24'h0, req);
    chk("isr_rst", RESET_ADDR, isr);
    @(posedge clk);
    rst_n <= 1'b1;
    // every named source alone, prompt return
    for (k = 0; k < 6; k++) begin
      prio[4*irqs[k] +: 4] <= 4'h4;
      fire(246'h1 << irqs[k], 6'h00);
      serve(irqs[k], adrs[k]);
    end
    // equal level: lower vector first
    fire((246'h1 << 177) | (246'h1 << 178), 6'h00);
    serve(177, adrs[2]);
    serve(178, adrs[3]);
    // higher level beats lower number
    prio[4*179 +: 4] <= 4'h6;
    fire((246'h1 << 173) | (246'h1 << 179), 6'h00);
    serve(179, adrs[4]);
    serve(173, adrs[0]);
    // trap 0 outranks every source
    fire(246'h1 << 173, 6'h01);
    serve(-1, PRIMARY_TABLE_BASE);
    serve(173, adrs[0]);
    // core priority and enable gate the request
    cpu_prio <= 3'h4;
    quiet(246'h1 << 173);
    cpu_prio <= 3'h3;
    serve(173, adrs[0]);
    en[174] <= 1'b0;
    quiet(246'h1 << 174);
    en[174] <= 1'b1;
    serve(174, adrs[1]);
    // alternate table, four-page segment, slow core
    bseg <= 1'b1;
    fuse <= 1'b1;
    blim <= 13'h0004;
    alt_en <= 1'b1;
    prot <= 1'b1;
    ret_dly <= 4'h9;
    fire(246'h1 << 174, 6'h00);
    serve(174, 24'h00_1800 + 24'h00_016C);
    chk("alt", 24'h1, alt);
    chk("prot", 24'h1, prot_seen);
    fire('0, 6'h20);
    serve(-1, 24'h00_1800 + 24'h00_000A);
    // any one of segment, fuse, enable missing falls back to primary
    for (k = 0; k < 3; k++) begin
      bseg <= (k != 0);
      fuse <= (k != 1);
      alt_en <= (k != 2);
      fire(246'h1 << 174, 6'h00);
      serve(174, adrs[1]);
      chk("alt_off", 24'h0, alt);
    end
    // frozen clock enable: an event in the freeze is dropped, no request
    clk_en <= 1'b0;
    fire(246'h1 << 173, 6'h00);
    repeat (3) @(posedge clk);
    #1;
    chk("frozen_flag", 24'h0, flags[173]);
    chk("frozen_req", 24'h0, req);
    @(posedge clk);
    clk_en <= 1'b1;
    // dma channels land on their own sources
    for (k = 0; k < 4; k++) begin
      prio[4*(16+k) +: 4] <= 4'h5;
      @(posedge clk);
      dma <= 4'h1 << k;
      @(posedge clk);
      dma <= 4'h0;
      serve(16 + k, 24'h00_0004 + 24'(2*(24+k)));
    end
    wrap_up();
  end
endmodule
